//--- hw/fmas_defs.svh
`ifndef FMAS_DEFS_SVH
`define FMAS_DEFS_SVH
// ==========================================================
// timing
`define FMAS_CLK_NS          25
`define FMAS_TICK_NS         250
`define FMAS_TICK_CYC        ((`FMAS_TICK_NS + `FMAS_CLK_NS - 1) / `FMAS_CLK_NS)
`define FMAS_FLOAT_MIN_NS    4000
`define FMAS_FLOAT_MIN_TICKS ((`FMAS_FLOAT_MIN_NS + `FMAS_TICK_NS - 1) / `FMAS_TICK_NS)
// ==========================================================
// register byte offsets
`define FMAS_ADR_CTRL   8'h00
`define FMAS_ADR_STAT   8'h04
`define FMAS_ADR_AB     8'h08
`define FMAS_ADR_CD     8'h0c
`define FMAS_ADR_EF     8'h10
`define FMAS_ADR_LED    8'h14
`define FMAS_ADR_PER    8'h18
`define FMAS_ADR_CNT    8'h1c
// ==========================================================
// field positions
`define FMAS_CTRL_RUN   0
`define FMAS_CTRL_LED   1
`define FMAS_STAT_BUSY  0
`define FMAS_STAT_ERR   1
`define FMAS_STAT_HOLD  2
// ==========================================================
// reset values, in ticks
`define FMAS_RST_PA     16'h0004
`define FMAS_RST_PB     16'h0010
`define FMAS_RST_PC     16'h0014
`define FMAS_RST_PD     16'h001c
`define FMAS_RST_PE     16'h0024
`define FMAS_RST_PF     16'h002c
`define FMAS_RST_LEDON  16'h0006
`define FMAS_RST_LEDOFF 16'h001a
`define FMAS_RST_PER    16'h0040
`endif

//--- hw/fmas_pkg.sv
package fmas_pkg;
  // sequencer phases
  typedef enum logic [1:0] {FMAS_IDLE, FMAS_FLOAT, FMAS_HOLD, FMAS_TAIL} fmas_phase_t;
  // whole state of the sequencer
  typedef struct packed {
    fmas_phase_t  ph;
    logic [15:0]  cnt;
    logic [15:0]  pulses;
    logic         run;
    logic         ledEn;
    logic         cfgErr;
    logic [15:0]  pa, pb, pc, pd, pe, pf;
    logic [15:0]  ledOn, ledOff, period;
    logic         pdConnect, tiaConnect, intReset, intPositive;
    logic         intNegative, intHold, ledDrive, bpfBypass, adcSample;
    logic         ack;
    logic [31:0]  dat;
  } fmas_state_t;
endpackage

//--- hw/fmas_tick_div.sv
`timescale 1ns/1ps
`include "fmas_defs.svh"
// ==========================================================
// timing tick divider: one-cycle enable every tick period
module fmas_tick_div (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic restart,
  output logic      tick
);
  logic [7:0] divQ;  // cycle counter within a tick
  logic [7:0] divD;
  logic       tickD;

  // count cycles, restart aligns the tick grid to a period
  always_comb begin
    divD  = divQ + 8'h01;
    tickD = 1'b0;
    if (restart) begin
      divD = 8'h00;
    end else if (divQ == 8'(`FMAS_TICK_CYC - 1)) begin
      divD  = 8'h00;
      tickD = 1'b1;
    end
  end

  // register divider
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      divQ <= 8'h00;
      tick <= 1'b0;
    end else begin
      divQ <= divD;
      tick <= tickD;
    end
  end
endmodule // fmas_tick_div

//--- hw/fmas_seq.sv
`timescale 1ns/1ps
`include "fmas_defs.svh"
// How it works
// - float interval at least four microseconds
// - photodiode stays connected during precondition
// - point A disconnects the photodiode
// - amplifier isolated while the photodiode floats
// - integrator cleared just before positive phase
// - point B starts positive integration
// - point C starts negative integration until F
// - point D reconnects photodiode for charge dump
// - point E disconnects the amplifier
// - point F holds integrator until converter samples
// - LED pulse lies between A and D
// - float mode bypasses the band-pass filter
// - charge dump lies inside negative phase
module fmas_seq
  import fmas_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [7:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatW,
  output logic [31:0]      wbDatR,
  output logic             wbAck,
  input  wire logic        adcDone,
  output logic             pdConnect,
  output logic             tiaConnect,
  output logic             intReset,
  output logic             intPositive,
  output logic             intNegative,
  output logic             intHold,
  output logic             ledDrive,
  output logic             bpfBypass,
  output logic             adcSample
);
  // ==========================================================
  // state and helpers
  fmas_state_t s_q;      // all registered state
  fmas_state_t s_d;      // next state
  logic        tick;     // one-cycle timing tick
  logic        restart;  // realigns the tick grid
  logic        cfgOk;    // programmed points are usable
  logic        busWr;    // accepted write this cycle
  logic        busRd;    // accepted read this cycle
  logic        inFloat;  // photodiode floating at next state

  // half-open range test on tick counts
  function automatic logic inRange(input logic [15:0] c,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
    inRange = (c >= lo) && (c < hi);
  endfunction

  // byte-lane merge of a write into a word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // ==========================================================
  // tick divider
  fmas_tick_div u_div (
    .clk     (clk),
    .rstn    (rstn),
    .restart (restart),
    .tick    (tick)
  );

  assign restart = (s_q.ph == FMAS_IDLE);

  // ==========================================================
  // configuration check
  always_comb begin
    // ordered points, float long enough, LED inside float
    cfgOk = (s_q.pa < s_q.pb) && (s_q.pb < s_q.pc) &&
            (s_q.pc < s_q.pd) && (s_q.pd < s_q.pe) &&
            (s_q.pe < s_q.pf) && (s_q.pf < s_q.period) &&
            (s_q.pa != 16'h0000) &&
            ((s_q.pd - s_q.pa) >= 16'(`FMAS_FLOAT_MIN_TICKS)) &&
            (!s_q.ledEn || ((s_q.ledOn >= s_q.pa) &&
                            (s_q.ledOff <= s_q.pd) &&
                            (s_q.ledOn < s_q.ledOff)));
  end

  assign busWr = wbCyc && wbStb && wbWe && !s_q.ack;
  assign busRd = wbCyc && wbStb && !wbWe && !s_q.ack;

  // ==========================================================
  // next state
  always_comb begin
    logic [31:0] w;
    logic        errSet;
    logic        errClr;
    w      = 32'h0000_0000;
    errSet = 1'b0;
    errClr = 1'b0;
    s_d    = s_q;
    s_d.ack       = busWr || busRd;
    s_d.adcSample = 1'b0;

    // register writes
    if (busWr) begin
      case (wbAdr)
        `FMAS_ADR_CTRL: begin
          w = merge({30'h0, s_q.ledEn, s_q.run}, wbDatW, wbSel);
          s_d.run   = w[`FMAS_CTRL_RUN];
          s_d.ledEn = w[`FMAS_CTRL_LED];
        end
        `FMAS_ADR_STAT: begin
          // write one clears the error flag
          errClr = wbSel[0] && wbDatW[`FMAS_STAT_ERR];
        end
        `FMAS_ADR_AB:  {s_d.pb, s_d.pa} = merge({s_q.pb, s_q.pa}, wbDatW, wbSel);
        `FMAS_ADR_CD:  {s_d.pd, s_d.pc} = merge({s_q.pd, s_q.pc}, wbDatW, wbSel);
        `FMAS_ADR_EF:  {s_d.pf, s_d.pe} = merge({s_q.pf, s_q.pe}, wbDatW, wbSel);
        `FMAS_ADR_LED: {s_d.ledOff, s_d.ledOn} = merge({s_q.ledOff, s_q.ledOn}, wbDatW, wbSel);
        `FMAS_ADR_PER: begin
          w = merge({16'h0000, s_q.period}, wbDatW, wbSel);
          s_d.period = w[15:0];
        end
        default: w = 32'h0000_0000;  // unmapped or read-only: acked, ignored
      endcase
    end

    // register reads
    if (busRd) begin
      case (wbAdr)
        `FMAS_ADR_CTRL: s_d.dat = {30'h0, s_q.ledEn, s_q.run};
        `FMAS_ADR_STAT: s_d.dat = {29'h0, s_q.intHold, s_q.cfgErr,
                                   s_q.ph != FMAS_IDLE};
        `FMAS_ADR_AB:   s_d.dat = {s_q.pb, s_q.pa};
        `FMAS_ADR_CD:   s_d.dat = {s_q.pd, s_q.pc};
        `FMAS_ADR_EF:   s_d.dat = {s_q.pf, s_q.pe};
        `FMAS_ADR_LED:  s_d.dat = {s_q.ledOff, s_q.ledOn};
        `FMAS_ADR_PER:  s_d.dat = {16'h0000, s_q.period};
        `FMAS_ADR_CNT:  s_d.dat = {s_q.pulses, s_q.cnt};
        default:        s_d.dat = 32'h0000_0000;
      endcase
    end

    // sequencer walk over one pulse period
    case (s_q.ph)
      FMAS_IDLE: begin
        s_d.cnt = 16'h0000;
        if (s_q.run) begin
          if (cfgOk) begin
            s_d.ph = FMAS_FLOAT;
          end else begin
            // bad timing refused: stop and flag
            s_d.run = 1'b0;
            errSet  = 1'b1;
          end
        end
      end
      FMAS_FLOAT: begin
        if (tick) begin
          s_d.cnt = s_q.cnt + 16'h0001;
          if (s_q.cnt >= s_q.pf - 16'h0001) begin
            // reaching the final point: freeze at once, no idle gap
            s_d.ph        = FMAS_HOLD;
            s_d.adcSample = 1'b1;
          end
        end
      end
      FMAS_HOLD: begin
        // keep holding until the converter has sampled
        if (adcDone) begin
          s_d.ph = FMAS_TAIL;
        end
      end
      FMAS_TAIL: begin
        if (tick) begin
          if (s_q.cnt >= s_q.period - 16'h0001) begin
            // end of period: next pulse or stop
            s_d.pulses = s_q.pulses + 16'h0001;
            s_d.cnt    = 16'h0000;
            if (!s_q.run) begin
              s_d.ph = FMAS_IDLE;
            end else if (!cfgOk) begin
              s_d.ph  = FMAS_IDLE;
              s_d.run = 1'b0;
              errSet  = 1'b1;
            end else begin
              s_d.ph = FMAS_FLOAT;
            end
          end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
          end
        end
      end
      default: begin
        s_d.ph = FMAS_IDLE;
      end
    endcase

    // error flag: a new set beats a clear
    s_d.cfgErr = (s_q.cfgErr && !errClr) || errSet;

    // switch outputs from the next phase and count
    inFloat        = (s_d.ph == FMAS_FLOAT) &&
                     inRange(s_d.cnt, s_d.pa, s_d.pd);
    s_d.pdConnect  = !inFloat;
    s_d.tiaConnect = (s_d.ph == FMAS_FLOAT) ?
                     (s_d.cnt < s_d.pa) ||
                     inRange(s_d.cnt, s_d.pd, s_d.pe) :
                     (s_d.ph == FMAS_IDLE);
    s_d.intReset   = (s_d.ph == FMAS_FLOAT) &&
                     (s_d.cnt == s_d.pb - 16'h0001);
    s_d.intPositive = (s_d.ph == FMAS_FLOAT) &&
                      inRange(s_d.cnt, s_d.pb, s_d.pc);
    s_d.intNegative = (s_d.ph == FMAS_FLOAT) &&
                      inRange(s_d.cnt, s_d.pc, s_d.pf);
    s_d.intHold    = (s_d.ph == FMAS_HOLD);
    s_d.ledDrive   = s_d.ledEn && (s_d.ph == FMAS_FLOAT) &&
                     inRange(s_d.cnt, s_d.ledOn, s_d.ledOff);
    s_d.bpfBypass  = (s_d.ph != FMAS_IDLE);
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q             <= '0;
      s_q.ph          <= FMAS_IDLE;
      s_q.pa          <= `FMAS_RST_PA;
      s_q.pb          <= `FMAS_RST_PB;
      s_q.pc          <= `FMAS_RST_PC;
      s_q.pd          <= `FMAS_RST_PD;
      s_q.pe          <= `FMAS_RST_PE;
      s_q.pf          <= `FMAS_RST_PF;
      s_q.ledOn       <= `FMAS_RST_LEDON;
      s_q.ledOff      <= `FMAS_RST_LEDOFF;
      s_q.period      <= `FMAS_RST_PER;
      s_q.pdConnect   <= 1'b1;
      s_q.tiaConnect  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign wbDatR      = s_q.dat;
  assign wbAck       = s_q.ack;
  assign pdConnect   = s_q.pdConnect;
  assign tiaConnect  = s_q.tiaConnect;
  assign intReset    = s_q.intReset;
  assign intPositive = s_q.intPositive;
  assign intNegative = s_q.intNegative;
  assign intHold     = s_q.intHold;
  assign ledDrive    = s_q.ledDrive;
  assign bpfBypass   = s_q.bpfBypass;
  assign adcSample   = s_q.adcSample;

  // ==========================================================
  // checks
  sequence s_clear_then_pos;
    intReset ##[1:10] intPositive;
  endsequence

  property p_float_min;
    @(posedge clk) disable iff (!rstn)
      $fell(pdConnect) |-> ((s_q.pd - s_q.pa) >= 16'(`FMAS_FLOAT_MIN_TICKS));
  endproperty
  a_float_min: assert property (p_float_min)
    else $error("float interval shorter than minimum");

  property p_precond;
    @(posedge clk) disable iff (!rstn)
      (s_q.ph == FMAS_FLOAT && s_q.cnt < s_q.pa) |-> pdConnect && tiaConnect;
  endproperty
  a_precond: assert property (p_precond)
    else $error("photodiode not connected in precondition");

  property p_point_a;
    @(posedge clk) disable iff (!rstn)
      $fell(pdConnect) |-> (s_q.cnt == s_q.pa) && !tiaConnect;
  endproperty
  a_point_a: assert property (p_point_a)
    else $error("photodiode released away from point A");

  property p_tia_iso;
    @(posedge clk) disable iff (!rstn)
      !pdConnect |-> !tiaConnect;
  endproperty
  a_tia_iso: assert property (p_tia_iso)
    else $error("amplifier connected while floating");

  property p_clear;
    @(posedge clk) disable iff (!rstn)
      $rose(intReset) |-> s_clear_then_pos;
  endproperty
  a_clear: assert property (p_clear)
    else $error("integrator clear not followed by positive phase");

  property p_pos;
    @(posedge clk) disable iff (!rstn)
      $rose(intPositive) |-> !pdConnect && (s_q.cnt == s_q.pb);
  endproperty
  a_pos: assert property (p_pos)
    else $error("positive phase not at point B while floating");

  property p_neg;
    @(posedge clk) disable iff (!rstn)
      $rose(intNegative) |-> $past(intPositive) && (s_q.cnt == s_q.pc);
  endproperty
  a_neg: assert property (p_neg)
    else $error("negative phase not at point C");

  property p_dump;
    @(posedge clk) disable iff (!rstn)
      ($rose(pdConnect) && s_q.ph == FMAS_FLOAT) |->
        intNegative && tiaConnect && (s_q.cnt == s_q.pd);
  endproperty
  a_dump: assert property (p_dump)
    else $error("reconnect outside negative phase or point D");

  property p_point_e;
    @(posedge clk) disable iff (!rstn)
      ($fell(tiaConnect) && pdConnect) |-> intNegative && (s_q.cnt == s_q.pe);
  endproperty
  a_point_e: assert property (p_point_e)
    else $error("amplifier detach not at point E");

  property p_hold;
    @(posedge clk) disable iff (!rstn)
      (intHold && !adcDone) |=> intHold;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold released before sample");

  property p_led;
    @(posedge clk) disable iff (!rstn)
      ledDrive |-> !pdConnect;
  endproperty
  a_led: assert property (p_led)
    else $error("LED pulse outside float interval");

  property p_bypass;
    @(posedge clk) disable iff (!rstn)
      (intPositive || intNegative || intHold) |-> bpfBypass;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("filter not bypassed in float cycle");
endmodule // fmas_seq

//--- tb/fmas_afe_model.sv
`timescale 1ns/1ps
// ==========================================================
// receive chain stand-in: answers a sample request after a delay
// reference level and bias set-up belong to software; the sequencer drives the filter bypass
module fmas_afe_model (
  input  wire logic clk,       // system clock
  input  wire logic rstn,      // async reset, active low
  input  wire logic slow,      // high: converter takes longer
  input  wire logic intHold,   // integrator output frozen
  input  wire logic adcSample, // sample request pulse
  output logic      adcDone    // sampling finished pulse
);
  // converter state
  typedef struct packed {
    logic       busy;
    logic [3:0] cnt;
    logic       done;
  } fmas_afe_t;
  fmas_afe_t q, d;

  // ==========================================================
  // next state: count down, then report while the value is held
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (adcSample) begin
      d.busy = 1'b1;
      d.cnt  = slow ? 4'h7 : 4'h0;
    end else if (q.busy) begin
      if (q.cnt == 4'h0) begin
        d.busy = 1'b0;
        d.done = intHold;
      end else begin
        d.cnt = q.cnt - 4'h1;
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign adcDone = q.done;
endmodule // fmas_afe_model

//--- tb/tb_top.sv
`timescale 1ns/1ps
`include "fmas_defs.svh"
// ==========================================================
// self-checking bench for the float sequencer
module tb_top;
  logic        clk, rstn, wbCyc, wbStb, wbWe, adcDone, slowDone;
  logic [7:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDatW, wbDatR;
  logic        wbAck, pdConnect, tiaConnect, intReset, intPositive;
  logic        intNegative, intHold, ledDrive, bpfBypass, adcSample;
  int          err_count, checks_done, cyc, tA;
  int          dSeen[8];     // event offsets from float start, in cycles
  int          expQ[$];      // expected offsets, nine per period
  logic [32:0] ackQ[$];      // {compare, expected read data} per bus cycle
  logic [8:0]  cur, prv;     // watched edges
  logic        holdP, doneSeen;
  logic [7:0]  adrTab[8];
  logic [31:0] rstTab[8];

  fmas_seq u_dut (.clk(clk), .rstn(rstn), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
    .adcDone(adcDone), .pdConnect(pdConnect), .tiaConnect(tiaConnect),
    .intReset(intReset), .intPositive(intPositive), .intNegative(intNegative),
    .intHold(intHold), .ledDrive(ledDrive), .bpfBypass(bpfBypass), .adcSample(adcSample));
  fmas_afe_model u_afe (.clk(clk), .rstn(rstn), .slow(slowDone), .intHold(intHold),
    .adcSample(adcSample), .adcDone(adcDone));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // ==========================================================
  // comparison and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (err_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================
  // classic single bus cycle, held until ack is sampled
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                      input logic [31:0] dat, input logic cmp, input logic [31:0] exp);
    ackQ.push_back({cmp, exp});
    wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we; wbAdr <= adr; wbSel <= sel; wbDatW <= dat;
    do begin
      @(posedge clk);
    end while (wbAck !== 1'b1);
    wbCyc <= 1'b0; wbStb <= 1'b0; wbWe <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    xfer(1'b1, adr, 4'hf, dat, 1'b0, 32'h0);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    xfer(1'b0, adr, 4'hf, 32'h0, 1'b1, exp);
  endtask

  // ==========================================================
  // random legal timing, two periods with expected offsets noted
  task automatic runCfg(input logic led);
    logic [15:0] a, b, c, dd, e, f, lo, lf, per;
    a  = 16'(1 + $urandom % 4);
    b  = a + 16'(2 + $urandom % 3);
    c  = b + 16'(1 + $urandom % 3);
    dd = (c + 16'h1 < a + 16'h10) ? a + 16'h10 : c + 16'h1;
    dd = dd + 16'($urandom % 3);
    e  = dd + 16'(8 + $urandom % 4);
    f  = e + 16'(1 + $urandom % 3);
    per = f + 16'(2 + $urandom % 4);
    lo = a + 16'($urandom % 2);
    lf = lo + 16'h1 + 16'($urandom % (dd - lo));
    wr(`FMAS_ADR_AB, {b, a});
    wr(`FMAS_ADR_CD, {dd, c});
    wr(`FMAS_ADR_EF, {f, e});
    wr(`FMAS_ADR_LED, {lf, lo});
    wr(`FMAS_ADR_PER, {16'h0, per});
    repeat (2) begin
      expQ.push_back(int'(b - 16'h1 - a) * 10);
      expQ.push_back(int'(b - a) * 10);
      expQ.push_back(int'(c - a) * 10);
      expQ.push_back(int'(dd - a) * 10);
      expQ.push_back(int'(dd - a) * 10);
      expQ.push_back(int'(e - a) * 10);
      expQ.push_back(led ? int'(lo - a) * 10 : -1);
      expQ.push_back(led ? int'(lf - a) * 10 : -1);
      expQ.push_back(int'(f - a) * 10);
    end
    wr(`FMAS_ADR_CTRL, {30'h0, led, 1'b1});
    while (expQ.size() != 0) begin
      @(posedge clk);
    end
    wr(`FMAS_ADR_CTRL, 32'h0);
    repeat (int'(per) * 10 + 60) @(posedge clk);
    rd(`FMAS_ADR_STAT, 32'h0);
  endtask

  // ==========================================================
  // bus answer watcher: oldest note against each ack
  always @(posedge clk) begin
    if (wbAck === 1'b1) begin
      if (ackQ.size() == 0) begin
        check(32'h1, 32'h0);
      end else if (ackQ[0][32]) begin
        check(wbDatR, 32'(ackQ.pop_front()));
      end else begin
        void'(ackQ.pop_front());
      end
    end
  end

  // ==========================================================
  // sequence watcher: edge offsets from float start, hold behaviour
  always @(posedge clk) begin
    cyc++;
    if (cyc > 30000) begin
      err_count++;
      complete_run();
    end
    cur = {adcSample, !ledDrive, ledDrive, !tiaConnect, tiaConnect, pdConnect,
           intNegative, intPositive, intReset};
    if (prv[3] === 1'b1 && pdConnect === 1'b0) begin
      tA = cyc;
      foreach (dSeen[i]) dSeen[i] = -1;
      check(32'(expQ.size() != 0), 32'h1);
      check(tiaConnect, 32'h0);
      check(bpfBypass, 32'h1);
    end
    for (int i = 0; i < 8; i++) begin
      if (cur[i] === 1'b1 && prv[i] === 1'b0 && dSeen[i] < 0 && (cyc > tA || i == 6)) begin
        dSeen[i] = cyc - tA;
      end
    end
    if (adcSample === 1'b1) begin
      check(intHold, 32'h1);
      for (int i = 0; i < 8; i++) begin
        check(dSeen[i], expQ.pop_front());
      end
      check(cyc - tA, expQ.pop_front());
    end
    if (intHold === 1'b1 && adcDone === 1'b1) begin
      doneSeen = 1'b1;
    end
    if (holdP === 1'b1 && intHold === 1'b0) begin
      check(doneSeen, 32'h1);
      doneSeen = 1'b0;
    end
    holdP = intHold;
    prv = cur;
  end

  // ==========================================================
  // main sequence
  initial begin
    clk = 0; rstn = 0; wbCyc = 0; wbStb = 0; wbWe = 0; wbAdr = 0; wbSel = 0;
    wbDatW = 0; slowDone = 0; err_count = 0; checks_done = 0; cyc = 0; tA = 0;
    prv = '0; holdP = 0; doneSeen = 0;
    void'($urandom(75441));
    adrTab = '{`FMAS_ADR_CTRL, `FMAS_ADR_STAT, `FMAS_ADR_AB, `FMAS_ADR_CD,
               `FMAS_ADR_EF, `FMAS_ADR_LED, `FMAS_ADR_PER, 8'h20};
    rstTab = '{32'h0, 32'h0, {`FMAS_RST_PB, `FMAS_RST_PA}, {`FMAS_RST_PD, `FMAS_RST_PC},
               {`FMAS_RST_PF, `FMAS_RST_PE}, {`FMAS_RST_LEDOFF, `FMAS_RST_LEDON},
               {16'h0, `FMAS_RST_PER}, 32'h0};
    repeat (2) @(posedge clk);
    check({pdConnect, tiaConnect, intReset, intPositive, intNegative, intHold,
           ledDrive, bpfBypass, adcSample, wbAck}, 32'h300);
    rstn <= 1'b1;
    @(posedge clk);
    foreach (adrTab[i]) rd(adrTab[i], rstTab[i]);
    // upper lanes only
    xfer(1'b1, `FMAS_ADR_AB, 4'b1100, 32'h1234_abcd, 1'b0, 32'h0);
    rd(`FMAS_ADR_AB, {16'h1234, `FMAS_RST_PA});
    // float time one tick short of the minimum is refused
    wr(`FMAS_ADR_AB, {16'h0008, 16'h0004});
    wr(`FMAS_ADR_CD, {16'h0013, 16'h000a});
    wr(`FMAS_ADR_EF, {16'h0018, 16'h0016});
    wr(`FMAS_ADR_LED, {16'h0010, 16'h0005});
    wr(`FMAS_ADR_PER, 32'h0000_001e);
    wr(`FMAS_ADR_CTRL, 32'h1);
    repeat (5) @(posedge clk);
    rd(`FMAS_ADR_STAT, 32'h2);
    rd(`FMAS_ADR_CTRL, 32'h0);
    wr(`FMAS_ADR_STAT, 32'h2);
    rd(`FMAS_ADR_STAT, 32'h0);
    // random legal timings, prompt and slow converter, with and without LED
    for (int k = 0; k < 4; k++) begin
      slowDone <= k[0];
      runCfg(k[1]);
      rd(`FMAS_ADR_CNT, {16'(2 * k + 2), 16'h0000});
    end
    complete_run();
  end
endmodule // tb_top
